// ===== rtl/snc_core.sv
// Purpose: Command decoder, status byte and array read/write of a serial
//          byte memory acting as a serial-peripheral slave
// Assumes: cs_b, sck, si, guard_pin_b are synchronous to clk and sck is
//          slower than clk/2, so every serial edge is seen
// Notes:   Array is plain flip-flops; contents are not reset
//          Sleep modes only gate the pins; power handling lies elsewhere
//          Hibernate recovery length is a parameter so a bench can shorten it
//          Fast, ident, serial-number and special-sector opcodes run nothing
//
// Overview of operation
// - Status bit 7 is the status guard, written and read by status commands.
// - Status bits 6..4 store written values and read back unchanged.
// - Status bits 3..2 are block guard bits, written and read.
// - Bit 1 is the write permit flag, set/clear by commands, not status write.
// - Permit flag clears at reset, clear command and wake from sleep modes.
// - Permit flag stays set after status, serial-number and special-sector writes.
// - Status bit 0 always reads zero and never changes.
// - A frame ending before eight opcode bits executes nothing.
// - Decode 06 set permit, 04 clear permit, 05 status read.
// - Decode 03 array read, 02 array write, 0B fast read.
// - Decode BA deep sleep, B9 hibernate, 9F part ident read.
// - Decode 42 special write, 4B special read, 49 fast special read.
// - Exactly sixteen opcodes recognised, including 4C, C2 and C3.
// - With permit flag clear, all write commands change nothing.
// - Status read shifts the status byte out repeatedly, ignoring input.
// - Status write takes eight bits, ignoring incoming bits 1 and 0.
// - Array read: opcode, 16-bit address, then bytes out until deselect.
// - Read address advances every byte and wraps to zero.
// - Input sampled on rising serial clock, output changes on falling.
// - Only serial modes 0 and 3 are supported.
// - Deselected: output released, all other inputs ignored.
// - Block guard shields none, C000 up, 8000 up, or all from writes.
`default_nettype none

module snc_core
    import snc_pkg::*;
#(
    parameter int unsigned REC_HIB_CYC = snc_pkg::REC_HIB_CYC_DEF
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic cs_b,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic guard_pin_b,
    output var  logic so,
    output var  logic so_oe
);

    import snc_pkg::*;

    // ==========================================================
    // Declarations
    // Registers
    logic               sck_d_r;
    logic               cs_d_r;
    logic [2:0]         bit_cnt_r;
    logic [6:0]         shift_r;
    snc_state_t         state_r;
    logic               addr_hi_done_r;
    logic               is_write_r;
    logic [ADDR_W-1:0]  addr_r;
    snc_status_t        stat_r;
    logic [7:0]         out_byte_r;
    logic               sleep_pend_r;
    logic               sleep_hib_r;
    logic               asleep_r;
    logic               rec_busy_r;
    logic [REC_W-1:0]   rec_cnt_r;
    logic               so_r;
    logic               so_oe_r;
    logic [7:0]         mem_r [MEM_SIZE];

    // Combinational nets
    logic               awake;
    logic               sck_rise;
    logic               sck_fall;
    logic               cs_rise;
    logic               cs_fall;
    logic               byte_done;
    logic [7:0]         in_byte;
    logic [ADDR_W-1:0]  addr_full;
    logic               stat_wr_ok;
    logic               arr_blocked;
    logic               wake_done;

    // ==========================================================
    // Edge detection and framing
    // Pins are taken as synchronous; edges show one clk late, which fixes
    // the output lag at one clk after the falling edge is seen
    // Deselect gates both serial clock edges
    assign awake     = ~asleep_r & ~rec_busy_r;
    assign sck_rise  = ~cs_b & awake & sck & ~sck_d_r;
    assign sck_fall  = ~cs_b & awake & ~sck & sck_d_r;
    assign cs_rise   = cs_b & ~cs_d_r;
    assign cs_fall   = ~cs_b & cs_d_r;
    assign byte_done = sck_rise & (bit_cnt_r == BIT_LAST);
    assign in_byte   = {shift_r, si};
    assign addr_full = {addr_r[ADDR_W-2:0], si};
    assign wake_done = rec_busy_r & (rec_cnt_r == REC_W'(1));

    // Status write needs permit plus either guard off or pin high
    // Guard pin matters only while the guard bit is set
    assign stat_wr_ok = stat_r.write_permit_flag
                        & (~stat_r.status_guard_bit | guard_pin_b);

    // Block guard region check
    // Upper two address bits pick the quarter, so the compare stays tiny
    always_comb begin
        case ({stat_r.block_guard_high, stat_r.block_guard_low})
            BG_NONE:    arr_blocked = 1'b0;
            BG_QUARTER: arr_blocked = (addr_r[ADDR_W-1 -: 2] == QUARTER_TOP);
            BG_HALF:    arr_blocked = addr_r[ADDR_W-1];
            BG_ALL:     arr_blocked = 1'b1;
            default:    arr_blocked = 1'b1;
        endcase
    end

    // Previous pin levels; both idle levels of the clock work alike
    // Mode 0 and 3 share edges
    // Chip select resets high so no false deselect edge follows reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_d_r <= 1'b0;
            cs_d_r  <= 1'b1;
        end else begin
            sck_d_r <= sck;
            cs_d_r  <= cs_b;
        end
    end

    // ==========================================================
    // Bit counter and input shifter
    // Partial opcode dropped
    // Counter runs modulo eight, so byte boundaries line up in every phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else if (cs_b || !awake) begin
            bit_cnt_r <= 3'h0;
            shift_r   <= 7'h00;
        end else if (sck_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= in_byte[6:0];
        end
    end

    // ==========================================================
    // Frame state machine
    // One command per frame; a finished command idles in skip until
    // deselect, which is also how surplus bits are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r        <= ST_OPCODE;
            addr_hi_done_r <= 1'b0;
            is_write_r     <= 1'b0;
        end else if (cs_b) begin
            state_r        <= ST_OPCODE;
            addr_hi_done_r <= 1'b0;
        end else if (!awake) begin
            // Frame that woke the part carries no command
            state_r <= ST_SKIP;
        end else if (byte_done) begin
            case (state_r)
                ST_OPCODE: begin
                    case (in_byte)
                        OP_STAT_READ:   state_r <= ST_STAT_OUT;
                        OP_STAT_WRITE:  state_r <= ST_STAT_IN;
                        OP_ARRAY_READ: begin
                            state_r    <= ST_ADDR;
                            is_write_r <= 1'b0;
                        end
                        OP_ARRAY_WRITE: begin
                            state_r    <= ST_ADDR;
                            is_write_r <= 1'b1;
                        end
                        // Fast read is not carried; its frame idles
                        // Sleep opcodes act at deselect; frame idles
                        // Special sector opcodes idle the frame
                        // Ident and serial-number opcodes idle too
                        OP_FAST_READ, OP_DEEP_SLEEP, OP_HIBERNATE, OP_PART_IDENT,
                        OP_UNIQUE_IDENT, OP_SERIAL_WRITE, OP_SERIAL_READ,
                        OP_SPECIAL_WR, OP_SPECIAL_RD, OP_SPECIAL_FRD: begin
                            state_r <= ST_SKIP;
                        end
                        // Permit opcodes finish with the opcode itself
                        OP_SET_PERMIT, OP_CLR_PERMIT: state_r <= ST_SKIP;
                        // Reserved and undefined codes run nothing
                        default:        state_r <= ST_SKIP;
                    endcase
                end
                ST_ADDR: begin
                    addr_hi_done_r <= 1'b1;
                    if (addr_hi_done_r) begin
                        state_r <= is_write_r ? ST_WR_DATA : ST_RD_DATA;
                    end
                end
                ST_STAT_IN: state_r <= ST_SKIP;
                default:    state_r <= state_r;
            endcase
        end
    end

    // ==========================================================
    // Address register
    // Advance per byte, wraps by width
    // FFFF plus one drops its carry, so the wrap costs no logic
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= '0;
        end else if (sck_rise && state_r == ST_ADDR) begin
            addr_r <= addr_full;
        end else if (byte_done && (state_r == ST_RD_DATA || state_r == ST_WR_DATA)) begin
            addr_r <= addr_r + ADDR_W'(1);
        end
    end

    // ==========================================================
    // Status byte
    // Set and clear come from distinct opcodes and cannot collide; a wake
    // clear never meets an opcode, as no input is taken during recovery
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_r <= STATUS_RST;
        end else if (wake_done) begin
            stat_r.write_permit_flag <= 1'b0;
        end else if (byte_done && state_r == ST_OPCODE) begin
            if (in_byte == OP_SET_PERMIT) begin
                stat_r.write_permit_flag <= 1'b1;
            end else if (in_byte == OP_CLR_PERMIT) begin
                stat_r.write_permit_flag <= 1'b0;
            end
        end else if (byte_done && state_r == ST_STAT_IN && stat_wr_ok) begin
            stat_r.status_guard_bit <= in_byte[7];
            stat_r.spare_bits       <= in_byte[6:4];
            stat_r.block_guard_high <= in_byte[3];
            stat_r.block_guard_low  <= in_byte[2];
            // Permit left set; bit 0 untouched
        end
    end

    // ==========================================================
    // Array storage; nonvolatile contents need no reset
    // Full 64K byte array
    // Writes need permit flag
    // Byte lands on the edge that completes it; a short trailing byte is lost
    always_ff @(posedge clk) begin
        if (byte_done && state_r == ST_WR_DATA && stat_r.write_permit_flag
            && !arr_blocked) begin
            mem_r[addr_r] <= in_byte;
        end
    end

    // ==========================================================
    // Outgoing byte, reloaded as each byte boundary passes
    // Fetching one byte ahead has it ready for the first falling edge,
    // at the cost of a second read port on the array
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_byte_r <= 8'h00;
        end else if (byte_done) begin
            case (state_r)
                ST_OPCODE, ST_STAT_OUT: out_byte_r <= stat_r;
                ST_ADDR:    out_byte_r <= mem_r[addr_full];
                ST_RD_DATA: out_byte_r <= mem_r[addr_r + ADDR_W'(1)];
                default:    out_byte_r <= out_byte_r;
            endcase
        end
    end

    // Serial output; bit index follows the rising-edge count
    // Output changes on falling edge
    // Released when deselected
    // so keeps its last level while released; only so_oe tells them apart
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else if (cs_b || !awake) begin
            so_oe_r <= 1'b0;
        end else if (sck_fall && (state_r == ST_RD_DATA || state_r == ST_STAT_OUT)) begin
            so_oe_r <= 1'b1;
            so_r    <= out_byte_r[BIT_LAST - bit_cnt_r];
        end
    end

    assign so    = so_r;
    assign so_oe = so_oe_r;

    // ==========================================================
    // Sleep modes: entered on deselect, cancelled by any extra clock
    // Sleep opcodes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_pend_r <= 1'b0;
            sleep_hib_r  <= 1'b0;
        end else if (byte_done && state_r == ST_OPCODE) begin
            sleep_pend_r <= (in_byte == OP_DEEP_SLEEP) || (in_byte == OP_HIBERNATE);
            sleep_hib_r  <= (in_byte == OP_HIBERNATE);
        end else if (sck_rise || cs_rise) begin
            sleep_pend_r <= 1'b0;
        end
    end

    // Wake starts on select; the part stays deaf until the count expires
    // Limitation: a second select inside recovery is not checked; the
    // master must hold chip select as it is until the count runs out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            asleep_r   <= 1'b0;
            rec_busy_r <= 1'b0;
            rec_cnt_r  <= '0;
        end else if (cs_rise && sleep_pend_r) begin
            asleep_r <= 1'b1;
        end else if (asleep_r && cs_fall) begin
            asleep_r   <= 1'b0;
            rec_busy_r <= 1'b1;
            rec_cnt_r  <= sleep_hib_r ? REC_W'(REC_HIB_CYC) : REC_W'(REC_DEEP_CYC);
        end else if (rec_busy_r) begin
            rec_busy_r <= ~wake_done;
            rec_cnt_r  <= rec_cnt_r - REC_W'(1);
        end
    end

endmodule

`default_nettype wire

// ===== rtl/snc_pkg.sv
// Purpose: Shared constants and types for the serial memory command core
// Assumes: 50 MHz system clock; pins arrive synchronous to it
// Notes:   Opcodes, status layout and wake-up timing live here only
`default_nettype none

package snc_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int unsigned REC_DEEP_NS     = 10_000;
    localparam int unsigned REC_HIB_NS      = 450_000;
    // Longest wake times, so round down
    localparam int unsigned REC_DEEP_CYC    = REC_DEEP_NS / CLK_PERIOD_NS;
    localparam int unsigned REC_HIB_CYC_DEF = REC_HIB_NS / CLK_PERIOD_NS;
    localparam int unsigned REC_W           = 16;

    // ==========================================================
    // Framing
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned MEM_SIZE = 1 << ADDR_W;
    localparam logic [2:0]  BIT_LAST = 3'h7;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_SET_PERMIT   = 8'h06;
    localparam logic [7:0] OP_CLR_PERMIT   = 8'h04;
    localparam logic [7:0] OP_STAT_READ    = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE   = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
    localparam logic [7:0] OP_FAST_READ    = 8'h0B;
    localparam logic [7:0] OP_DEEP_SLEEP   = 8'hBA;
    localparam logic [7:0] OP_HIBERNATE    = 8'hB9;
    localparam logic [7:0] OP_PART_IDENT   = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_IDENT = 8'h4C;
    localparam logic [7:0] OP_SERIAL_WRITE = 8'hC2;
    localparam logic [7:0] OP_SERIAL_READ  = 8'hC3;
    localparam logic [7:0] OP_SPECIAL_WR   = 8'h42;
    localparam logic [7:0] OP_SPECIAL_RD   = 8'h4B;
    localparam logic [7:0] OP_SPECIAL_FRD  = 8'h49;

    // ==========================================================
    // Block guard codes
    localparam logic [1:0] BG_NONE    = 2'h0;
    localparam logic [1:0] BG_QUARTER = 2'h1;
    localparam logic [1:0] BG_HALF    = 2'h2;
    localparam logic [1:0] BG_ALL     = 2'h3;
    localparam logic [1:0] QUARTER_TOP = 2'h3;

    // ==========================================================
    // Status byte, bit 7 down to bit 0
    typedef struct packed {
        logic       status_guard_bit;
        logic [2:0] spare_bits;
        logic       block_guard_high;
        logic       block_guard_low;
        logic       write_permit_flag;
        logic       fixed_zero;
    } snc_status_t;

    localparam snc_status_t STATUS_RST = 8'h00;

    // ==========================================================
    // Frame states
    typedef enum logic [2:0] {
        ST_OPCODE   = 3'b000,
        ST_ADDR     = 3'b001,
        ST_RD_DATA  = 3'b010,
        ST_WR_DATA  = 3'b011,
        ST_STAT_OUT = 3'b100,
        ST_STAT_IN  = 3'b101,
        ST_SKIP     = 3'b110
    } snc_state_t;

endpackage

`default_nettype wire

// ===== bench/snc_core_sva.sv
// Purpose: Port checks for the serial memory command core
// Assumes: One clk domain, rst_b async active low
// Notes:   Counts serial rises per frame to judge when output may start
`default_nettype none

module snc_core_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sck,
    input wire logic si,
    input wire logic guard_pin_b,
    input wire logic so,
    input wire logic so_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk); endclocking

    // ==========================================================
    // Frame rise counter
    logic       sck_q_r;
    logic [7:0] rise_cnt_r;

    // Saturates so a long read never wraps back into the start window
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_q_r    <= 1'b0;
            rise_cnt_r <= 8'h00;
        end else begin
            sck_q_r <= sck;
            if (cs_b) begin
                rise_cnt_r <= 8'h00;
            end else if (sck && !sck_q_r && rise_cnt_r != 8'hFF) begin
                rise_cnt_r <= rise_cnt_r + 8'h01;
            end
        end
    end

    // ==========================================================
    // Output timing
    sequence s_fell_seen;
        !$past(sck) && $past(sck, 2);
    endsequence

    chk_oe_in_reset: assert property (!rst_b |-> !so_oe)
        else $error("output enabled during reset");
    chk_oe_deselect: assert property (disable iff (!rst_b) $past(cs_b) |-> !so_oe)
        else $error("output enabled while deselected");
    chk_so_on_fall: assert property (disable iff (!rst_b)
        so_oe && $past(so_oe) && $changed(so) |-> s_fell_seen)
        else $error("serial output moved off a falling edge");
    chk_oe_on_fall: assert property (disable iff (!rst_b) $rose(so_oe) |-> s_fell_seen)
        else $error("output enable rose off a falling edge");
    chk_oe_start_cnt: assert property (disable iff (!rst_b) $rose(so_oe) |->
        rise_cnt_r == 8'h08 || rise_cnt_r == 8'h18)
        else $error("output began at a wrong bit count");
    chk_no_early_out: assert property (disable iff (!rst_b) so_oe |-> rise_cnt_r >= 8'h08)
        else $error("output before the opcode was complete");
    chk_oe_holds: assert property (disable iff (!rst_b) so_oe && !cs_b |=> so_oe)
        else $error("output stopped inside a selected frame");
    chk_frame_quiet: assert property (disable iff (!rst_b)
        $fell(cs_b) |-> !so_oe ##1 !so_oe)
        else $error("output at frame start");
    chk_read_seen: cover property (disable iff (!rst_b) $rose(so_oe));
endmodule

bind snc_core snc_core_sva snc_core_sva_i (
    .clk         (clk),
    .rst_b       (rst_b),
    .cs_b        (cs_b),
    .sck         (sck),
    .si          (si),
    .guard_pin_b (guard_pin_b),
    .so          (so),
    .so_oe       (so_oe)
);

`default_nettype wire

// ===== bench/snc_host.sv
// Purpose: Serial master model driving the memory core pins
// Assumes: Pins change on falling clk; each serial level held 3 clocks
// Notes:   cpol selects mode 0 or mode 3; released output reads as z
`default_nettype none

module snc_host (
    input  wire logic clk,
    input  wire logic so,
    input  wire logic so_oe,
    output var  logic cs_b,
    output var  logic sck,
    output var  logic si
);
    timeunit 1ns;
    timeprecision 1ps;

    logic cpol = 1'b0;

    // ==========================================================
    // Pin drive
    initial begin
        cs_b = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic open_frame();
        sck <= cpol;
        wait_n(3);
        cs_b <= 1'b0;
        wait_n(3);
    endtask

    task automatic shift(input int n, input logic [7:0] d, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck <= 1'b0;
            si  <= d[i];
            wait_n(3);
            sck <= 1'b1;
            q[i] = so_oe ? so : 1'bz;
            wait_n(3);
        end
    endtask

    // Data line flips on release so a stale bit is never read as valid
    task automatic close_frame();
        sck <= cpol;
        wait_n(3);
        cs_b <= 1'b1;
        si   <= ~si;
        wait_n(3);
    endtask
endmodule

`default_nettype wire

// ===== bench/snc_core_tb.sv
// Purpose: Self-checking bench for the serial memory command core
// Assumes: Hibernate recovery shortened to 40 clocks
// Notes:   Expected values are built here from the opcode and status layout
`default_nettype none

module snc_core_tb
    import snc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       rst_b;
    logic       guard_pin_b;
    logic       cs_b;
    logic       sck;
    logic       si;
    logic       so;
    logic       so_oe;
    logic [7:0] tx [6];
    logic [7:0] rx [6];
    int         n_errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;

    // ==========================================================
    // Instances
    snc_core #(.REC_HIB_CYC(40)) snc_core_i (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
        .sck(sck), .si(si), .guard_pin_b(guard_pin_b), .so(so), .so_oe(so_oe));
    snc_host snc_host_i (.clk(clk), .so(so), .so_oe(so_oe), .cs_b(cs_b), .sck(sck), .si(si));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] op, input int n);
        logic [7:0] q;
        snc_host_i.open_frame();
        snc_host_i.shift(8, op, q);
        for (int i = 0; i < n; i++) begin
            snc_host_i.shift(8, tx[i], rx[i]);
        end
        snc_host_i.close_frame();
    endtask

    task automatic cmd(input logic [7:0] op);
        xfer(op, 0);
    endtask

    // Two bytes read back so the repeat is checked too
    task automatic chk_stat(input logic [7:0] exp);
        tx[0] = 8'h5A;
        tx[1] = 8'hC3;
        xfer(OP_STAT_READ, 2);
        cmp8(rx[0], exp);
        cmp8(rx[1], exp);
    endtask

    task automatic wr_stat(input logic [7:0] d);
        tx[0] = d;
        xfer(OP_STAT_WRITE, 1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_permit(input logic mode3);
        logic [7:0] q;
        snc_host_i.cpol = mode3;
        chk_stat(8'h00);
        snc_host_i.open_frame();
        snc_host_i.shift(5, OP_SET_PERMIT, q);
        snc_host_i.close_frame();
        chk_stat(8'h00);
        cmd(OP_SET_PERMIT);
        chk_stat(8'h02);
        cmd(OP_CLR_PERMIT);
        chk_stat(8'h00);
        wr_stat(8'hFC);
        chk_stat(8'h00);
        snc_host_i.cpol = 1'b0;
        $display("test_permit done, mode3=%0d", mode3);
    endtask

    task automatic test_status_write();
        cmd(OP_SET_PERMIT);
        wr_stat(8'hFD);
        chk_stat(8'hFE);
        guard_pin_b <= 1'b0;
        wr_stat(8'h00);
        chk_stat(8'hFE);
        guard_pin_b <= 1'b1;
        wr_stat(8'h51);
        chk_stat(8'h52);
        cmd(OP_CLR_PERMIT);
        chk_stat(8'h50);
        $display("test_status_write done");
    endtask

    task automatic test_array();
        cmd(OP_SET_PERMIT);
        tx = '{8'hFF, 8'hFF, 8'h11, 8'h22, 8'h33, 8'h00};
        xfer(OP_ARRAY_WRITE, 5);
        cmd(OP_CLR_PERMIT);
        tx[2] = 8'hEE;
        xfer(OP_ARRAY_WRITE, 3);
        tx = '{8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
        xfer(OP_ARRAY_READ, 5);
        cmp8(rx[1], 8'hZZ);
        cmp8(rx[2], 8'h11);
        cmp8(rx[3], 8'h22);
        cmp8(rx[4], 8'h33);
        $display("test_array done");
    endtask

    task automatic test_guard();
        logic [7:0] bf;
        logic [7:0] c0;
        bf = 8'h00;
        c0 = 8'h00;
        for (int g = 0; g < 4; g++) begin
            cmd(OP_SET_PERMIT);
            wr_stat({4'h0, 2'(g), 2'h0});
            chk_stat({4'h0, 2'(g), 2'h2});
            cmd(OP_SET_PERMIT);
            tx = '{8'hBF, 8'hFF, 8'h20 + 8'(g), 8'h30 + 8'(g), 8'h00, 8'h00};
            xfer(OP_ARRAY_WRITE, 4);
            if (g == 0) begin
                c0 = tx[3];
            end
            if (g < 2) begin
                bf = tx[2];
            end
            tx = '{8'hBF, 8'hFF, 8'hA5, 8'h5A, 8'h00, 8'h00};
            xfer(OP_ARRAY_READ, 4);
            cmp8(rx[2], bf);
            cmp8(rx[3], c0);
        end
        wr_stat(8'h00);
        $display("test_guard done");
    endtask

    task automatic test_skip();
        logic [7:0] ops [8];
        ops = '{OP_FAST_READ, OP_PART_IDENT, OP_UNIQUE_IDENT, OP_SERIAL_READ,
                OP_SPECIAL_RD, OP_SPECIAL_FRD, OP_SERIAL_WRITE, OP_SPECIAL_WR};
        tx = '{8'hA5, 8'h5A, 8'hA5, 8'h5A, 8'hA5, 8'h5A};
        foreach (ops[i]) begin
            xfer(ops[i], 4);
            cmp8(rx[3], 8'hZZ);
        end
        chk_stat(8'h02);
        $display("test_skip done");
    endtask

    task automatic test_sleep();
        logic [7:0] ops [2];
        ops = '{OP_DEEP_SLEEP, OP_HIBERNATE};
        foreach (ops[i]) begin
            cmd(OP_SET_PERMIT);
            cmd(ops[i]);
            xfer(OP_STAT_READ, 1);
            cmp8(rx[0], 8'hZZ);
            snc_host_i.wait_n(520);
            chk_stat(8'h00);
        end
        $display("test_sleep done");
    endtask

    // ==========================================================
    // Main sequence and hang guard
    initial begin
        rst_b       = 1'b0;
        guard_pin_b = 1'b1;
        repeat (5) @(negedge clk);
        rst_b <= 1'b1;
        repeat (2) @(negedge clk);
        test_permit(1'b0);
        test_permit(1'b1);
        test_status_write();
        test_array();
        test_guard();
        test_skip();
        test_sleep();
        give_verdict();
    end

    // Ceiling sits well above the roughly 12000 cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict();
        end
    end
endmodule

`default_nettype wire
